// *** pkg/host_port_pkg.sv ***
// constants shared by the host port, its buffer and its synchroniser
package host_port_pkg;
   // ----------------------------------------
   // host byte addresses (7-bit bus)
   // ----------------------------------------
   localparam logic [6:0] ADDR_STATUS_LO = 7'h04;
   localparam logic [6:0] ADDR_STATUS_HI = 7'h05;
   localparam logic [6:0] ADDR_ERROR_0   = 7'h08;
   localparam logic [6:0] ADDR_LBA_0     = 7'h10;
   localparam logic [6:0] ADDR_LBA_3     = 7'h13;
   localparam logic [6:0] ADDR_COUNT     = 7'h14;
   localparam logic [6:0] ADDR_CMD       = 7'h15;
   localparam logic [6:0] ADDR_CTRL_LO   = 7'h18;
   localparam logic [6:0] ADDR_CTRL_HI   = 7'h19;
   localparam logic [6:0] ADDR_FIFO_LO   = 7'h40;
   // ----------------------------------------
   // word indices (byte address / 2)
   // ----------------------------------------
   localparam logic [5:0] IDX_STATUS = 6'h02;
   localparam logic [5:0] IDX_ERR_LO = 6'h04;
   localparam logic [5:0] IDX_ERR_HI = 6'h05;
   localparam logic [5:0] IDX_LBA_LO = 6'h08;
   localparam logic [5:0] IDX_LBA_HI = 6'h09;
   localparam logic [5:0] IDX_CNTCMD = 6'h0A;
   localparam logic [5:0] IDX_CTRL   = 6'h0C;
   // ----------------------------------------
   // control bits
   // ----------------------------------------
   localparam int CTRL_LOCK_OVERRIDE = 0;
   localparam int CTRL_LOCK_REQUEST  = 1;
   localparam int CTRL_MODE_OVERRIDE = 3;
   localparam int CTRL_WAIT_FOR_GO   = 4;
   localparam int CTRL_CONFIG_GO     = 5;
   localparam int CTRL_SOURCE_SELECT = 6;
   localparam int CTRL_CHAIN_HOLD    = 7;
   localparam int CTRL_WORD_MODE     = 8;
   // ----------------------------------------
   // status bits
   // ----------------------------------------
   localparam int STAT_CHAIN_LOCK  = 0;
   localparam int STAT_HOST_LOCK   = 1;
   localparam int STAT_CFG_ERROR   = 2;
   localparam int STAT_BUF_READY   = 5;
   localparam int STAT_CFG_DONE    = 7;
   localparam int STAT_CMD_READY   = 8;
   localparam int STAT_CARD_BUSY   = 9;
   // ----------------------------------------
   // codes, sizes and reset values
   // ----------------------------------------
   localparam logic [7:0]  CMD_CARD_WRITE = 8'h04;
   localparam logic [3:0]  LBA_TOP_BITS   = 4'h0;
   localparam int          FIFO_WIDTH     = 16;
   localparam int          FIFO_DEPTH     = 16;
   localparam int          SYNC_STAGES    = 2;
   localparam logic [15:0] CTRL_RESET     = 16'h0000;
   localparam logic [31:0] LBA_RESET      = 32'h0000_0000;
   localparam logic [15:0] CNTCMD_RESET   = 16'h0000;
endpackage : host_port_pkg

// *** logic/pin_sync.sv ***
// two-stage synchroniser bank for host pins
module pin_sync #(
   parameter int              W        = 1,
   parameter logic [W-1:0]    RST_VAL  = '0
) (
   input  wire logic          clk_in,    // system clock
   input  wire logic          rst_n_in,  // async reset, active low
   input  wire logic [W-1:0]  d_in,      // asynchronous levels
   output logic      [W-1:0]  q_out      // synchronised levels
);
   logic [W-1:0] meta_q;

   // ----------------------------------------
   // first stage feeds only the second stage
   // ----------------------------------------
   always_ff @(posedge clk_in or negedge rst_n_in)
   begin
      if (!rst_n_in)
      begin
         meta_q <= RST_VAL;
         q_out  <= RST_VAL;
      end
      else
      begin
         meta_q <= d_in;
         q_out  <= meta_q;
      end
   end
endmodule : pin_sync

// *** logic/word_fifo.sv ***
// flip-flop fifo with valid/ready on both sides
module word_fifo #(
   parameter int W     = 16,
   parameter int DEPTH = 16
) (
   input  wire logic          clk_in,      // system clock
   input  wire logic          rst_n_in,    // async reset, active low
   input  wire logic          wr_valid_in, // push request
   output logic               wr_ready_out,// room for a word
   input  wire logic [W-1:0]  wr_data_in,  // pushed word
   output logic               rd_valid_out,// word available
   input  wire logic          rd_ready_in, // consumer takes word
   output logic      [W-1:0]  rd_data_out, // head word
   output logic               empty_out,   // nothing stored
   output logic [$clog2(DEPTH):0] count_out // words stored
);
   localparam int AW = $clog2(DEPTH);
   initial
   begin
      if (DEPTH < 2 || (1 << AW) != DEPTH)
         $error("word_fifo: DEPTH must be a power of two, at least 2");
   end

   logic [W-1:0]  mem_q [DEPTH];
   logic [AW:0]   wp_q;
   logic [AW:0]   rp_q;
   wire           push = wr_valid_in && wr_ready_out;
   wire           pop  = rd_valid_out && rd_ready_in;

   // ----------------------------------------
   // flags from the pointer difference
   // ----------------------------------------
   assign count_out    = wp_q - rp_q;
   assign empty_out    = (wp_q == rp_q);
   assign wr_ready_out = (count_out != (AW+1)'(DEPTH));
   assign rd_valid_out = !empty_out;
   assign rd_data_out  = mem_q[rp_q[AW-1:0]];

   // pointers carry an extra wrap bit so full and empty differ
   always_ff @(posedge clk_in or negedge rst_n_in)
   begin
      if (!rst_n_in)
      begin
         wp_q <= '0;
         rp_q <= '0;
      end
      else
      begin
         if (push) wp_q <= wp_q + 1'b1;
         if (pop)  rp_q <= rp_q + 1'b1;
      end
   end

   // storage has no reset; empty flags guard stale words
   always_ff @(posedge clk_in)
   begin
      if (push) mem_q[wp_q[AW-1:0]] <= wr_data_in;
   end
endmodule : word_fifo

// *** logic/host_port.sv ***
// host processor port: card lock, sector-write command and chain config
// Functional notes
// - block address taken as four bytes at 10h..13h, low byte first
// - command 04h written at 15h starts a card sector write
// - 32-byte, 16-word fifo aliased at every address 40h..7Fh
// - buffer ready only while the fifo is empty during a write or a host-fed chain config
// - byte mode: odd-address write advances fifo, even does not
// - word mode: every buffer-range write advances fifo one word
// - with chain held, control bit 6 selects host as data source
// - control bits 3 and 4 together override mode pin, wait for go
// - status bit 7 at 04h flags successful configuration
// - failure cause shown by other status bits and error register
// - control bit 1 requests lock; status bit 1 grants it
// - card command readiness on bit 0 of status byte 05h
// - buffer ready on status bit 5 and on a dedicated pin
// - control bits 7 and 0 together force the chain to drop its lock
module host_port (
   input  wire logic        clk_in,            // 25 MHz system clock
   input  wire logic        rst_n_in,          // async reset, active low
   input  wire logic [6:0]  host_addr_in,      // host byte address pins
   input  wire logic [15:0] host_data_in,      // host data pins, input side
   output logic      [15:0] host_data_out,     // host data pins, output side
   output logic             host_data_oe_out,  // high while driving data pins
   input  wire logic        host_cs_n_in,      // chip select pin, active low
   input  wire logic        host_wr_n_in,      // write strobe pin, active low
   input  wire logic        host_rd_n_in,      // read strobe pin, active low
   input  wire logic        mode_select_pin_in,// external chain mode pin
   output logic             buffer_ready_pin_out, // buffer ready pin
   input  wire logic        card_cmd_ready_in, // card accepts a command
   input  wire logic        card_write_done_in,// card write finished pulse
   input  wire logic        chain_lock_held_in,// chain controller owns card
   input  wire logic        config_finished_in,// chain configured
   input  wire logic        config_error_in,   // chain configuration failed
   input  wire logic [31:0] error_code_in,     // failure cause word
   output logic             card_write_go_out, // one-cycle write start
   output logic [27:0]      card_lba_out,      // first sector address
   output logic [7:0]       card_count_out,    // sectors to write
   output logic             chain_hold_out,    // chain controller in reset
   output logic             chain_release_out, // force chain to drop lock
   output logic             source_select_out, // host feeds chain data
   output logic             wait_for_go_out,   // chain waits for go signal
   output logic             config_go_out,     // chain start signal
   output logic [15:0]      drain_data_out,    // word to card or chain
   output logic             drain_valid_out,   // drain word valid
   input  wire logic        drain_ready_in     // card or chain takes word
);
   // ----------------------------------------
   // pin synchronisers
   // ----------------------------------------
   localparam int SW = 27;
   logic [SW-1:0] pins_s;
   pin_sync #(.W(SW), .RST_VAL({4'hF, 23'h000000})) u_sync (
      .clk_in   (clk_in),
      .rst_n_in (rst_n_in),
      .d_in     ({host_cs_n_in, host_wr_n_in, host_rd_n_in, mode_select_pin_in,
                  host_addr_in, host_data_in}),
      .q_out    (pins_s)
   );
   wire        cs_s   = !pins_s[26];
   wire        wr_s   = !pins_s[25];
   wire        rd_s   = !pins_s[24];
   wire        mpin_s = pins_s[23];
   wire [6:0]  addr_s = pins_s[22:16];
   wire [15:0] data_s = pins_s[15:0];

   logic        wr_prev_q;
   logic [15:0] ctrl_q;
   logic [31:0] lba_q;
   logic [15:0] cntcmd_q;
   logic        lock_q;
   logic        write_active_q;
   logic        load_full_q;
   logic        done_q;
   logic        err_q;
   logic [7:0]  stage_q;
   logic [15:0] status_w;

   // ----------------------------------------
   // write decode
   // ----------------------------------------
   // one strobe per host write, taken on the synchronised leading edge
   wire       wr_stb   = cs_s && wr_s && !wr_prev_q;
   wire       word_mode = ctrl_q[host_port_pkg::CTRL_WORD_MODE];
   wire [5:0] widx     = addr_s[6:1];
   wire       odd      = addr_s[0];
   wire       be_lo    = wr_stb && (word_mode || !odd);
   wire       be_hi    = wr_stb && (word_mode || odd);
   wire [7:0] wd_lo    = data_s[7:0];
   wire [7:0] wd_hi    = word_mode ? data_s[15:8] : data_s[7:0];
   wire       in_fifo  = addr_s[6];  // whole 40h..7Fh window aliases

   function automatic logic hit(input logic [5:0] a, input logic [5:0] b);
      hit = (a == b);
   endfunction : hit

   // ----------------------------------------
   // data buffer
   // ----------------------------------------
   logic        f_ready;
   logic        f_empty;
   logic [4:0]  f_count;
   wire         odd_byte_wr = wr_stb && in_fifo && !word_mode && odd;
   wire         word_wr     = wr_stb && in_fifo && word_mode;
   wire         push_req    = odd_byte_wr || word_wr;
   wire [15:0]  push_data   = word_mode ? data_s : {data_s[7:0], stage_q};
   wire         push        = push_req && f_ready;
   wire         f_valid;
   // drain only whole loads so each 32-byte block goes out together
   wire         drain_take  = f_valid && load_full_q && drain_ready_in;

   word_fifo #(.W(host_port_pkg::FIFO_WIDTH), .DEPTH(host_port_pkg::FIFO_DEPTH)) u_fifo (
      .clk_in       (clk_in),
      .rst_n_in     (rst_n_in),
      .wr_valid_in  (push_req),
      .wr_ready_out (f_ready),
      .wr_data_in   (push_data),
      .rd_valid_out (f_valid),
      .rd_ready_in  (load_full_q && drain_ready_in),
      .rd_data_out  (drain_data_out),
      .empty_out    (f_empty),
      .count_out    (f_count)
   );
   assign drain_valid_out = f_valid && load_full_q;

   // the buffer is in use for a card write or for host-fed chain config
   wire buf_active = write_active_q ||
                     (ctrl_q[host_port_pkg::CTRL_SOURCE_SELECT] &&
                      lock_q);
   wire last_push  = push && (f_count == 5'(host_port_pkg::FIFO_DEPTH - 1));

   // ----------------------------------------
   // status word
   // ----------------------------------------
   always_comb
   begin
      status_w = 16'h0000;
      status_w[host_port_pkg::STAT_CHAIN_LOCK] = chain_lock_held_in;
      status_w[host_port_pkg::STAT_HOST_LOCK]  = lock_q;
      status_w[host_port_pkg::STAT_CFG_ERROR]  = err_q;
      status_w[host_port_pkg::STAT_BUF_READY]  = buffer_ready_pin_out;
      status_w[host_port_pkg::STAT_CFG_DONE]   = done_q;
      status_w[host_port_pkg::STAT_CMD_READY]  = card_cmd_ready_in;
      status_w[host_port_pkg::STAT_CARD_BUSY]  = write_active_q;
   end

   // read mux; unmapped words and the fifo window read zero
   wire [15:0] rd_word =
      hit(widx, host_port_pkg::IDX_STATUS) ? status_w :
      hit(widx, host_port_pkg::IDX_ERR_LO) ? error_code_in[15:0] :
      hit(widx, host_port_pkg::IDX_ERR_HI) ? error_code_in[31:16] :
      hit(widx, host_port_pkg::IDX_LBA_LO) ? lba_q[15:0] :
      hit(widx, host_port_pkg::IDX_LBA_HI) ? lba_q[31:16] :
      hit(widx, host_port_pkg::IDX_CNTCMD) ? cntcmd_q :
      hit(widx, host_port_pkg::IDX_CTRL)   ? ctrl_q : 16'h0000;
   wire [15:0] rd_lane = (word_mode || !odd) ? rd_word : {8'h00, rd_word[15:8]};

   // ----------------------------------------
   // host bus registers
   // ----------------------------------------
   always_ff @(posedge clk_in or negedge rst_n_in)
   begin
      if (!rst_n_in)
      begin
         wr_prev_q        <= 1'b0;
         host_data_out    <= 16'h0000;
         host_data_oe_out <= 1'b0;
         stage_q          <= 8'h00;
      end
      else
      begin
         wr_prev_q        <= cs_s && wr_s;
         host_data_out    <= rd_lane;
         host_data_oe_out <= cs_s && rd_s && !wr_s;
         if (wr_stb && in_fifo && !word_mode && !odd)
            stage_q <= data_s[7:0];  // even byte waits for its odd partner
      end
   end

   // parameter and control registers
   always_ff @(posedge clk_in or negedge rst_n_in)
   begin
      if (!rst_n_in)
      begin
         lba_q    <= host_port_pkg::LBA_RESET;
         cntcmd_q <= host_port_pkg::CNTCMD_RESET;
         ctrl_q   <= host_port_pkg::CTRL_RESET;
      end
      else
      begin
         if (be_lo && hit(widx, host_port_pkg::IDX_LBA_LO)) lba_q[7:0]   <= wd_lo;
         if (be_hi && hit(widx, host_port_pkg::IDX_LBA_LO)) lba_q[15:8]  <= wd_hi;
         if (be_lo && hit(widx, host_port_pkg::IDX_LBA_HI)) lba_q[23:16] <= wd_lo;
         if (be_hi && hit(widx, host_port_pkg::IDX_LBA_HI))
            lba_q[31:24] <= {host_port_pkg::LBA_TOP_BITS, wd_hi[3:0]};
         if (be_lo && hit(widx, host_port_pkg::IDX_CNTCMD)) cntcmd_q[7:0]  <= wd_lo;
         if (be_hi && hit(widx, host_port_pkg::IDX_CNTCMD)) cntcmd_q[15:8] <= wd_hi;
         if (be_lo && hit(widx, host_port_pkg::IDX_CTRL))   ctrl_q[7:0]    <= wd_lo;
         if (be_hi && hit(widx, host_port_pkg::IDX_CTRL))   ctrl_q[15:8]   <= wd_hi;
      end
   end

   // ----------------------------------------
   // command, lock, buffer and chain state
   // ----------------------------------------
   wire cmd_wr = be_hi && hit(widx, host_port_pkg::IDX_CNTCMD) &&
                 (wd_hi == host_port_pkg::CMD_CARD_WRITE);
   wire hold   = ctrl_q[host_port_pkg::CTRL_CHAIN_HOLD];
   wire lreq   = ctrl_q[host_port_pkg::CTRL_LOCK_REQUEST];

   always_ff @(posedge clk_in or negedge rst_n_in)
   begin
      if (!rst_n_in)
      begin
         card_write_go_out    <= 1'b0;
         card_lba_out         <= 28'h0000000;
         card_count_out       <= 8'h00;
         write_active_q       <= 1'b0;
         lock_q               <= 1'b0;
         load_full_q          <= 1'b0;
         buffer_ready_pin_out <= 1'b0;
         done_q               <= 1'b0;
         err_q                <= 1'b0;
         chain_hold_out       <= 1'b0;
         chain_release_out    <= 1'b0;
         source_select_out    <= 1'b0;
         wait_for_go_out      <= 1'b0;
         config_go_out        <= 1'b0;
      end
      else
      begin
         card_write_go_out <= cmd_wr;
         if (cmd_wr)
         begin
            card_lba_out   <= lba_q[27:0];
            card_count_out <= cntcmd_q[7:0];
         end
         // a new command wins over a done pulse in the same cycle
         if (cmd_wr)
            write_active_q <= 1'b1;
         else if (card_write_done_in)
            write_active_q <= 1'b0;
         // grant only while the chain side does not hold the card
         lock_q <= lreq && (lock_q || !chain_lock_held_in);
         if (last_push)
            load_full_q <= 1'b1;
         else if (f_empty)
            load_full_q <= 1'b0;
         buffer_ready_pin_out <= buf_active && f_empty && !load_full_q && !push;
         // results are sticky until the chain is held in reset again
         if (config_finished_in)
            done_q <= 1'b1;
         else if (hold)
            done_q <= 1'b0;
         if (config_error_in)
            err_q <= 1'b1;
         else if (hold)
            err_q <= 1'b0;
         chain_hold_out    <= hold;
         chain_release_out <= hold && ctrl_q[host_port_pkg::CTRL_LOCK_OVERRIDE];
         source_select_out <= ctrl_q[host_port_pkg::CTRL_SOURCE_SELECT];
         wait_for_go_out   <= ctrl_q[host_port_pkg::CTRL_MODE_OVERRIDE] ?
                              ctrl_q[host_port_pkg::CTRL_WAIT_FOR_GO] : mpin_s;
         config_go_out     <= ctrl_q[host_port_pkg::CTRL_CONFIG_GO];
      end
   end

   // ----------------------------------------
   // assertions
   // ----------------------------------------
   sequence s_full_load;
      last_push ##1 load_full_q;
   endsequence
   property p_lba_top;
      @(posedge clk_in) disable iff (!rst_n_in) lba_q[31:28] == 4'h0;
   endproperty
   a_lba_top: assert property (p_lba_top) else $error("lba top bits set");
   property p_cmd_go;
      @(posedge clk_in) disable iff (!rst_n_in)
         cmd_wr |=> card_write_go_out && write_active_q;
   endproperty
   a_cmd_go: assert property (p_cmd_go) else $error("write command not started");
   property p_ready_empty;
      @(posedge clk_in) disable iff (!rst_n_in)
         buffer_ready_pin_out |-> $past(f_empty) && f_count <= 5'h01;
   endproperty
   a_ready_empty: assert property (p_ready_empty) else $error("ready with data");
   property p_full_block;
      @(posedge clk_in) disable iff (!rst_n_in)
         s_full_load |-> !buffer_ready_pin_out ##1 !buffer_ready_pin_out;
   endproperty
   a_full_block: assert property (p_full_block) else $error("ready after full load");
   property p_even_hold;
      @(posedge clk_in) disable iff (!rst_n_in)
         wr_stb && in_fifo && !word_mode && !odd |=> $stable(f_count) || $past(f_valid);
   endproperty
   a_even_hold: assert property (p_even_hold) else $error("even byte advanced");
   property p_word_push;
      @(posedge clk_in) disable iff (!rst_n_in)
         word_wr && f_ready && !drain_take |=> f_count == $past(f_count) + 5'h01;
   endproperty
   a_word_push: assert property (p_word_push) else $error("word write lost");
   property p_done;
      @(posedge clk_in) disable iff (!rst_n_in) config_finished_in |=> status_w[7];
   endproperty
   a_done: assert property (p_done) else $error("finish flag missing");
   property p_grant;
      @(posedge clk_in) disable iff (!rst_n_in)
         lreq && !chain_lock_held_in ##1 lreq |-> lock_q;
   endproperty
   a_grant: assert property (p_grant) else $error("lock not granted");
   property p_release;
      @(posedge clk_in) disable iff (!rst_n_in)
         hold && ctrl_q[0] |=> chain_release_out;
   endproperty
   a_release: assert property (p_release) else $error("force release missing");
   property p_mode;
      @(posedge clk_in) disable iff (!rst_n_in)
         ctrl_q[3] && ctrl_q[4] |=> wait_for_go_out;
   endproperty
   a_mode: assert property (p_mode) else $error("mode override ignored");
endmodule : host_port

// *** bench/host_cpu_model.sv ***
// host processor bus model driving the 16-bit register port
module host_cpu_model (
   input  wire logic        clk_in,    // system clock
   output logic      [6:0]  addr_out,  // byte address
   output logic      [15:0] data_out,  // write data
   output logic             cs_n_out,  // chip select, active low
   output logic             wr_n_out,  // write strobe, active low
   output logic             rd_n_out,  // read strobe, active low
   input  wire logic [15:0] rdata_in   // read data
);
   timeunit 1ns;
   timeprecision 100ps;
   // idle bus; released data shows the inverse so stale values never match
   initial
   begin
      {cs_n_out, wr_n_out, rd_n_out} = 3'h7;
      addr_out = 7'h00;
      data_out = 16'hFFFF;
   end
   // strobe held 4 clocks, idle 4 clocks: beats the 2-flop sync plus edge detect
   task automatic wr(input logic [6:0] a, input logic [15:0] d);
      @(posedge clk_in);
      #2 {addr_out, data_out, cs_n_out, wr_n_out} = {a, d, 2'b00};
      repeat (4) @(posedge clk_in);
      #2 {data_out, cs_n_out, wr_n_out} = {~d, 2'b11};
      repeat (4) @(posedge clk_in);
   endtask : wr
   // read data is taken 6 edges after the strobe, past the sync latency
   task automatic rd(input logic [6:0] a, output logic [15:0] d);
      @(posedge clk_in);
      #2 {addr_out, cs_n_out, rd_n_out} = {a, 2'b00};
      repeat (6) @(posedge clk_in);
      d = rdata_in;
      #2 {cs_n_out, rd_n_out} = 2'b11;
      repeat (4) @(posedge clk_in);
   endtask : rd
endmodule : host_cpu_model

// *** bench/host_sector_write_and_chain_config_tb_top.sv ***
// self-checking bench: lock, sector write, buffer loads, chain config
module host_sector_write_and_chain_config_tb_top;
   timeunit 1ns;
   timeprecision 100ps;
   logic clk = 0, rst_n = 0, done = 0, fin = 0, ferr = 0, dready = 0, drain = 0;
   logic [6:0] addr;
   logic [15:0] wd, rdat, r, dd;
   logic oe, brdy, go, hold, rel, src, wfg, cgo, dvalid, mpin;
   logic [27:0] lba_o;
   logic [7:0] cnt_o;
   logic [31:0] block_address, err;
   logic cs_n, wr_n, rd_n;
   logic chlock = 1, cmdrdy = 0;
   int fails = 0, check_count = 0, go_seen = 0, oe_seen = 0;
   logic [15:0] q[$];
   initial forever #20 clk = ~clk;
   host_cpu_model cpu_u (.clk_in(clk), .addr_out(addr), .data_out(wd), .cs_n_out(cs_n),
      .wr_n_out(wr_n), .rd_n_out(rd_n), .rdata_in(rdat));
   host_port dut_u (.clk_in(clk), .rst_n_in(rst_n), .host_addr_in(addr), .host_data_in(wd),
      .host_data_out(rdat), .host_data_oe_out(oe), .host_cs_n_in(cs_n), .host_wr_n_in(wr_n),
      .host_rd_n_in(rd_n), .mode_select_pin_in(mpin), .buffer_ready_pin_out(brdy),
      .card_cmd_ready_in(cmdrdy), .card_write_done_in(done), .chain_lock_held_in(chlock),
      .config_finished_in(fin), .config_error_in(ferr), .error_code_in(err),
      .card_write_go_out(go), .card_lba_out(lba_o), .card_count_out(cnt_o),
      .chain_hold_out(hold), .chain_release_out(rel), .source_select_out(src),
      .wait_for_go_out(wfg), .config_go_out(cgo), .drain_data_out(dd),
      .drain_valid_out(dvalid), .drain_ready_in(dready));
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      check_count++;
      if (got !== exp)
      begin
         fails++;
         $display("[ERR] %0t got %h exp %h", $time, got, exp);
      end
   endtask : chk
   task automatic complete_run();
      if (fails == 0 && check_count > 0)
         $display("ALL CHECKS OK");
      else
         $display("CHECKS NOT OK");
      $finish;
   endtask : complete_run
   // drained words leave in push order; consumer stalls at random
   always @(negedge clk)
   begin
      if (dvalid && dready)
         chk(dd, q.pop_front());
      if (go)
         go_seen++;
      if (oe)
         oe_seen++;
   end
   always @(posedge clk) dready <= #2 drain && ($urandom % 4 != 0);
   // ----------------------------------------
   // one 32-byte load at random aliased addresses, then drain
   // ----------------------------------------
   task automatic load(input bit word);
      logic [15:0] d;
      logic [6:0] a;
      chk(brdy, 1'b1);
      for (int j = 0; j < 16; j++)
      begin
         d = 16'($urandom);
         a = 7'h40 + 7'(($urandom % 32) * 2);
         if (word)
            cpu_u.wr(a | 7'($urandom % 2), d);
         else
         begin
            cpu_u.wr(a, {8'h5A, d[7:0]});
            cpu_u.wr(a | 7'h01, {8'hA5, d[15:8]});
         end
         q.push_back(d);
      end
      repeat (2) @(posedge clk);
      // a whole load is held: ready low, words offered to the consumer
      chk({brdy, dvalid}, 2'b01);
      drain = 1;
      for (int k = 0; k < 300 && q.size() > 0; k++) @(posedge clk);
      repeat (3) @(posedge clk);
      chk({brdy, 5'(q.size())}, {1'b1, 5'd0});
      drain = 0;
   endtask : load
   initial
   begin
      #(40 * 40000) fails++;
      complete_run();
   end
   initial
   begin
      block_address = $urandom(94230);
      block_address = $urandom;
      err = $urandom;
      mpin = 1'($urandom);
      repeat (20) @(posedge clk);
      #2 rst_n = 1;
      // chain side owns the card and the card is not ready at first
      cpu_u.rd(7'h04, r);
      chk(oe_seen, 32'd6);
      chk(r[7:0], 8'h01);
      chk(wfg, mpin);
      cpu_u.rd(7'h05, r);
      chk(r[0], 1'b0);
      cpu_u.wr(7'h18, 16'h0002);
      cpu_u.rd(7'h04, r);
      chk(r[1:0], 2'b01);
      #2 {chlock, cmdrdy} = 2'b01;
      cpu_u.rd(7'h04, r);
      chk(r[1:0], 2'b10);
      cpu_u.rd(7'h05, r);
      chk(r[0], 1'b1);
      for (int i = 0; i < 4; i++) cpu_u.wr(7'h10 + 7'(i), {8'h00, block_address[8*i+:8]});
      cpu_u.wr(7'h14, {8'h00, err[7:0]});
      cpu_u.wr(7'h15, 16'h0004);
      chk(go_seen, 32'd1);
      chk(cnt_o, err[7:0]);
      chk(lba_o, block_address[27:0]);
      cpu_u.rd(7'h13, r);
      chk(r[7:0], {4'h0, block_address[27:24]});
      cpu_u.wr(7'h18, 16'h0082);
      load(0);
      cpu_u.wr(7'h19, 16'h0001);
      load(1);
      @(posedge clk) #2 done = 1;
      @(posedge clk) #2 done = 0;
      // release the hold, then the lock, and see the grant drop
      cpu_u.wr(7'h18, 16'h0102);
      cpu_u.wr(7'h18, 16'h0100);
      cpu_u.rd(7'h04, r);
      chk(r[1], 1'b0);
      // chain setup from the host side, then release the hold and feed a load
      cpu_u.wr(7'h18, 16'h0102);
      cpu_u.wr(7'h18, 16'h01FA);
      chk({src, wfg, cgo, hold}, 4'hF);
      cpu_u.wr(7'h18, 16'h017A);
      load(1);
      @(posedge clk) #2 {fin, ferr} = 2'b11;
      @(posedge clk) #2 {fin, ferr} = 2'b00;
      cpu_u.rd(7'h04, r);
      chk({r[7], r[2]}, 2'b11);
      cpu_u.rd(7'h08, r);
      chk(r, err[15:0]);
      cpu_u.wr(7'h18, 16'h0181);
      chk(rel, 1'b1);
      complete_run();
   end
endmodule : host_sector_write_and_chain_config_tb_top
